// File: olcb_bank.sv
// Output limit clamp bank for output points 5 to 8 with AXI4-Lite register access
//
// Contract
// - clamp each point's output between its limits
// - scaled points read limits as engineering units
// - floor at odd word, ceiling next, 49-56
// - shared read-only BCD word of bad address
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "olcb_cfg.svh"

module olcb_bank (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [3:0][15:0] command_i,
	output logic [3:0][15:0] clamped_o,
	output logic irq_o
);

	// ------------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------------

	// Word value as a signed number under the given format
	function automatic logic signed [16:0] olcb_num(input logic [15:0] w, input logic bcd, input logic sgn);
		logic [16:0] mag;
		logic neg;
		mag = 17'h00000;
		neg = 1'b0;
		if (!bcd) begin
			olcb_num = sgn ? {w[15], w} : {1'b0, w};
		end else begin
			neg = sgn && (w[15:12] == `OLCB_BCD_NEG_DIGIT);
			mag = 17'(w[11:8]) * 17'd100 + 17'(w[7:4]) * 17'd10 + 17'(w[3:0]);
			if (!neg) begin
				mag = mag + 17'(w[15:12]) * 17'd1000;
			end
			olcb_num = neg ? -$signed(mag) : $signed(mag);
		end
	endfunction

	// Allowed range of a limit word for the active mode
	function automatic logic olcb_valid(input logic [15:0] w, input logic bcd, input logic scaled,
		input logic sgn_bin);
		logic low_ok;
		logic top_ok;
		low_ok = (w[11:8] <= `OLCB_BCD_DIGIT_MAX) && (w[7:4] <= `OLCB_BCD_DIGIT_MAX) &&
			(w[3:0] <= `OLCB_BCD_DIGIT_MAX);
		top_ok = (w[15:12] <= `OLCB_BCD_TOP_MAX) || (w[15:12] == `OLCB_BCD_NEG_DIGIT);
		if (bcd && scaled) begin
			olcb_valid = low_ok && top_ok;
		end else if (bcd) begin
			olcb_valid = low_ok && (w <= `OLCB_UNSCALED_BCD_MAX);
		end else if (scaled) begin
			olcb_valid = (w != `OLCB_SCALED_BIN_BAD);
		end else if (sgn_bin) begin
			olcb_valid = (w >= `OLCB_SIGNED_BIN_MIN) || (w <= `OLCB_SIGNED_BIN_MAX);
		end else begin
			olcb_valid = (w <= `OLCB_UNSCALED_BIN_MAX);
		end
	endfunction

	// Decimal word index to a BCD word
	function automatic logic [15:0] olcb_bcd(input logic [5:0] v);
		logic [5:0] tens;
		tens = v / 6'd10;
		olcb_bcd = {8'h00, tens[3:0], 4'(v - tens * 6'd10)};
	endfunction

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	olcb_pkg::olcb_limit_t limit [4];
	olcb_pkg::olcb_cfg_t cfg;
	logic [15:0] bad_addr;
	logic [7:0] status;
	logic [7:0] enable;
	logic aw_got;
	logic w_got;
	logic [5:0] aw_idx;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [7:0] ev_set;
	logic [7:0] ev_clr;
	logic [7:0] next_status;

	// Write decode of the held request
	logic wr_go;
	logic wr_is_limit;
	logic [2:0] wr_k;
	logic [1:0] wr_pt;
	logic [15:0] wr_cur;
	logic [15:0] wr_word;
	logic wr_scaled;
	logic wr_ok;
	logic wr_mapped;

	assign wr_go = aw_got && w_got && !s_axi_bvalid_o;
	assign wr_is_limit = (aw_idx >= `OLCB_IDX_P5_FLOOR) && (aw_idx <= `OLCB_IDX_P8_CEILING);
	assign wr_k = 3'(aw_idx - `OLCB_IDX_P5_FLOOR);
	assign wr_pt = wr_k[2:1];
	assign wr_cur = wr_k[0] ? limit[wr_pt].ceiling : limit[wr_pt].floor;
	assign wr_word = {w_strb[1] ? w_data[15:8] : wr_cur[15:8], w_strb[0] ? w_data[7:0] : wr_cur[7:0]};
	assign wr_scaled = cfg.scale_en[wr_pt];
	assign wr_ok = olcb_valid(wr_word, cfg.bcd_fmt, wr_scaled, cfg.signed_bin);
	assign wr_mapped = (aw_idx >= `OLCB_IDX_P5_FLOOR) && (aw_idx <= `OLCB_IDX_IRQ_ENABLE);

	// ------------------------------------------------------------------------
	// Write address and data channels
	// ------------------------------------------------------------------------

	// Both channels are taken in any order, then one response follows
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_idx <= 6'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `OLCB_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_idx <= s_axi_awaddr_i[7:2];
				aw_got <= 1'b1;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
				w_got <= 1'b1;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_go) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_mapped ? `OLCB_RESP_OKAY : `OLCB_RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Limit words and bad address record
	// ------------------------------------------------------------------------

	// Rejected words are not stored; stored words are not checked again when the config changes
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 4; i++) begin
				limit[i].floor <= `OLCB_FLOOR_RST;
				limit[i].ceiling <= `OLCB_CEILING_RST;
			end
			bad_addr <= `OLCB_BAD_ADDR_RST;
		end else if (wr_go && wr_is_limit) begin
			if (wr_ok) begin
				if (wr_k[0]) begin
					limit[wr_pt].ceiling <= wr_word;
				end else begin
					limit[wr_pt].floor <= wr_word;
				end
			end else begin
				bad_addr <= olcb_bcd(aw_idx);
			end
		end
	end

	// Configuration and interrupt enable
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg <= `OLCB_CONFIG_RST;
			enable <= `OLCB_ENABLE_RST;
		end else if (wr_go) begin
			if (aw_idx == `OLCB_IDX_CONFIG && w_strb[0]) begin
				cfg <= w_data[5:0];
			end
			if (aw_idx == `OLCB_IDX_IRQ_ENABLE && w_strb[0]) begin
				enable <= w_data[7:0];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Clamp datapath
	// ------------------------------------------------------------------------
	generate
		for (genvar p = 0; p < 4; p++) begin : g_point
			logic sgn;
			logic signed [16:0] cmd_n;
			logic signed [16:0] floor_n;
			logic signed [16:0] ceil_n;
			logic below;
			logic above;

			// scaled points compare signed engineering units
			assign sgn = cfg.scale_en[p] || (cfg.signed_bin && !cfg.bcd_fmt);
			assign cmd_n = olcb_num(command_i[p], cfg.bcd_fmt, sgn);
			assign floor_n = olcb_num(limit[p].floor, cfg.bcd_fmt, sgn);
			assign ceil_n = olcb_num(limit[p].ceiling, cfg.bcd_fmt, sgn);
			assign below = cmd_n < floor_n;
			assign above = cmd_n > ceil_n;

			always_ff @(posedge clock_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					clamped_o[p] <= `OLCB_FLOOR_RST;
				end else if (below) begin
					clamped_o[p] <= limit[p].floor;
				end else if (above) begin
					clamped_o[p] <= limit[p].ceiling;
				end else begin
					clamped_o[p] <= command_i[p];
				end
			end

			assign ev_set[`OLCB_ST_LIMIT_OVER_LSB + p] = wr_go && wr_is_limit && !wr_ok && (wr_pt == 2'(p));
			assign ev_set[`OLCB_ST_CLAMPED_LSB + p] = below || above;
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Status and interrupt
	// ------------------------------------------------------------------------
	assign ev_clr = (wr_go && aw_idx == `OLCB_IDX_IRQ_CLEAR && w_strb[0]) ? w_data[7:0] : 8'h00;
	// A new event in the clearing cycle wins over the clear
	assign next_status = (status & ~ev_clr) | ev_set;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status <= `OLCB_STATUS_RST;
			irq_o <= 1'b0;
		end else begin
			status <= next_status;
			irq_o <= |(next_status & enable);
		end
	end

	// ------------------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------------------
	logic [31:0] rd_word;
	logic rd_mapped;
	logic [5:0] rd_idx;
	logic [2:0] rd_k;

	assign rd_idx = s_axi_araddr_i[7:2];
	assign rd_k = 3'(rd_idx - `OLCB_IDX_P5_FLOOR);

	// Read mux; the clear word reads as zero
	always_comb begin
		rd_word = 32'h00000000;
		rd_mapped = 1'b1;
		if (rd_idx >= `OLCB_IDX_P5_FLOOR && rd_idx <= `OLCB_IDX_P8_CEILING) begin
			rd_word = {16'h0000, rd_k[0] ? limit[rd_k[2:1]].ceiling : limit[rd_k[2:1]].floor};
		end else if (rd_idx == `OLCB_IDX_BAD_ADDR) begin
			rd_word = {16'h0000, bad_addr};
		end else if (rd_idx == `OLCB_IDX_CONFIG) begin
			rd_word = {26'h0000000, cfg};
		end else if (rd_idx == `OLCB_IDX_STATUS) begin
			rd_word = {24'h000000, status};
		end else if (rd_idx == `OLCB_IDX_IRQ_ENABLE) begin
			rd_word = {24'h000000, enable};
		end else if (rd_idx != `OLCB_IDX_IRQ_CLEAR) begin
			rd_mapped = 1'b0;
		end
	end

	// One read at a time, answered the cycle after the address is taken
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= `OLCB_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd_word;
			s_axi_rresp_o <= rd_mapped ? `OLCB_RESP_OKAY : `OLCB_RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// File: olcb_bank_props.sv
// Bus handshake assertions for the output limit clamp bank
`timescale 1ns/10ps
`default_nettype none
module olcb_bank_props (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic irq_o
);
	// ----------------
	// Properties
	// ----------------
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	chk_aw_refused: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
		else $error("aw ready held after take");
	chk_w_refused: assert property (s_axi_wvalid_i && s_axi_wready_o |=> !s_axi_wready_o)
		else $error("w ready held after take");
	chk_b_timing: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
		else $error("write answer late");
	chk_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write answer dropped");
	chk_ready_back: assert property (s_axi_bvalid_o && s_axi_bready_i |=> s_axi_awready_o && s_axi_wready_o)
		else $error("write channels not reopened");
	chk_r_timing: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	chk_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read answer dropped");
	chk_rdata_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
		else $error("read upper half not zero");
	cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'b10);
	cover property (s_axi_rvalid_o && !s_axi_rready_i);
	cover property ($rose(irq_o));
endmodule
bind olcb_bank olcb_bank_props u_props (.clock_i(clock_i), .reset_n_i(reset_n_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
	.s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.irq_o(irq_o));
`default_nettype wire

// File: olcb_bank_tb.sv
// Self-checking bench for the output limit clamp bank
`timescale 1ns/10ps
`default_nettype none
`include "olcb_cfg.svh"
module olcb_bank_tb;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [3:0][15:0] command_i = '0;
	logic [3:0][15:0] clamped_o;
	logic irq_o, awr, wrd, bv, arr, rv, awv, wv, brd, arv, rrd;
	logic [7:0] aw_addr, ar_addr;
	logic [31:0] w_data, r_data, rdv;
	logic [1:0] b_resp, r_resp, rsp;
	logic [31:0] seed = 32'h868ea7a6;
	logic [15:0] lo, hi;
	logic [15:0] sc_cmd [4] = '{16'hf500, 16'h0150, 16'h0300, 16'hf050};
	logic [15:0] sc_exp [4] = '{16'hf100, 16'h0150, 16'h0200, 16'hf050};
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	// ----------------
	// Harness
	// ----------------
	always #2 clock_i = ~clock_i;
	olcb_host host (.clock_i(clock_i), .aw_rdy_i(awr), .w_rdy_i(wrd), .b_resp_i(b_resp), .b_vld_i(bv),
		.ar_rdy_i(arr), .r_data_i(r_data), .r_resp_i(r_resp), .r_vld_i(rv), .aw_addr_o(aw_addr), .aw_vld_o(awv),
		.w_data_o(w_data), .w_vld_o(wv), .b_rdy_o(brd), .ar_addr_o(ar_addr), .ar_vld_o(arv), .r_rdy_o(rrd));
	olcb_bank dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(awv),
		.s_axi_awready_o(awr), .s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wrd), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(bv), .s_axi_bready_i(brd),
		.s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(r_data),
		.s_axi_rresp_o(r_resp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrd), .command_i(command_i),
		.clamped_o(clamped_o), .irq_o(irq_o));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Valid BCD word, top digit below top
	function automatic logic [15:0] bcd(input logic [31:0] s, input int top);
		return {4'(s[15:12] % top), 4'(s[11:8] % 10), 4'(s[7:4] % 10), 4'(s[3:0] % 10)};
	endfunction
	// Unsigned BCD orders like plain hex
	function automatic logic [15:0] clampx(input logic [15:0] c, input logic [15:0] f, input logic [15:0] h);
		return (c < f) ? f : (c > h) ? h : c;
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Hang guard, well above the run length
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	// ----------------
	// Scenarios
	// ----------------
	initial begin
		repeat (5) @(posedge clock_i);
		reset_n_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			host.rd(6'h31 + 6'(i), rdv, rsp);
			check("limit reset", rdv, i[0] ? 32'h4095 : 32'h0);
		end
		host.rd(`OLCB_IDX_BAD_ADDR, rdv, rsp);
		check("bad address reset", rdv, 32'h0);
		host.wr(`OLCB_IDX_IRQ_ENABLE, 16'h000f, rsp);
		$display("reset test done");
		host.slow = 1'b1;
		for (int p = 0; p < 4; p++) begin
			seed = lfsr(seed);
			lo = bcd(seed, 2);
			hi = bcd(seed >> 16, 2) | 16'h2000;
			host.wr(6'h31 + 6'(2 * p), lo, rsp);
			host.wr(6'h32 + 6'(2 * p), hi, rsp);
			host.rd(6'h32 + 6'(2 * p), rdv, rsp);
			check("ceiling readback", rdv, {16'h0, hi});
			for (int k = 0; k < 6; k++) begin
				seed = lfsr(seed);
				command_i[p] <= (k == 0) ? 16'h0000 : (k == 1) ? 16'h3999 : bcd(seed, 4);
				repeat (2) @(posedge clock_i);
				check("clamped output", clamped_o[p], clampx(command_i[p], lo, hi));
			end
		end
		check("irq masked", irq_o, 1'b0);
		$display("clamp test done");
		host.wr(`OLCB_IDX_P6_CEILING, 16'h4096, rsp);
		host.rd(`OLCB_IDX_BAD_ADDR, rdv, rsp);
		check("bad address", rdv, 32'h0052);
		host.rd(`OLCB_IDX_STATUS, rdv, rsp);
		check("limit over", rdv[3:0], 4'h2);
		check("irq raised", irq_o, 1'b1);
		host.wr(`OLCB_IDX_BAD_ADDR, 16'h0000, rsp);
		host.rd(`OLCB_IDX_BAD_ADDR, rdv, rsp);
		check("bad address read only", rdv, 32'h0052);
		host.wr(`OLCB_IDX_IRQ_CLEAR, 16'h00ff, rsp);
		@(posedge clock_i);
		check("irq cleared", irq_o, 1'b0);
		$display("error test done");
		host.wr(`OLCB_IDX_CONFIG, 16'h0011, rsp);
		host.wr(`OLCB_IDX_P5_FLOOR, 16'hf100, rsp);
		host.wr(`OLCB_IDX_P5_CEILING, 16'h0200, rsp);
		for (int j = 0; j < 4; j++) begin
			command_i[0] <= sc_cmd[j];
			repeat (2) @(posedge clock_i);
			check("scaled clamp", clamped_o[0], sc_exp[j]);
		end
		// Clamp flag stays set after the clamp ends, until cleared
		host.rd(`OLCB_IDX_STATUS, rdv, rsp);
		check("clamp flag sticky", rdv[4], 1'b1);
		host.wr(`OLCB_IDX_IRQ_CLEAR, 16'h0010, rsp);
		host.rd(`OLCB_IDX_STATUS, rdv, rsp);
		check("clamp flag cleared", rdv[4], 1'b0);
		host.wr(`OLCB_IDX_CONFIG, 16'h0001, rsp);
		host.wr(`OLCB_IDX_P5_FLOOR, 16'h8001, rsp);
		host.rd(`OLCB_IDX_P5_FLOOR, rdv, rsp);
		check("binary floor edge", rdv, 32'h8001);
		host.wr(`OLCB_IDX_P5_FLOOR, 16'h8000, rsp);
		host.rd(`OLCB_IDX_BAD_ADDR, rdv, rsp);
		check("bad binary address", rdv, 32'h0049);
		host.rd(6'h00, rdv, rsp);
		check("unmapped read", rsp, 2'b10);
		host.wr(6'h00, 16'h0000, rsp);
		check("unmapped write", rsp, 2'b10);
		// Signed binary unscaled: plain hex order would pick the wrong bound
		host.wr(`OLCB_IDX_CONFIG, 16'h0020, rsp);
		check("config write", rsp, 2'b00);
		host.wr(`OLCB_IDX_P6_FLOOR, 16'hfc00, rsp);
		host.wr(`OLCB_IDX_P6_CEILING, 16'h0100, rsp);
		command_i[1] <= 16'hf000;
		repeat (2) @(posedge clock_i);
		check("signed floor clamp", clamped_o[1], 16'hfc00);
		command_i[1] <= 16'h0200;
		repeat (2) @(posedge clock_i);
		check("signed ceiling clamp", clamped_o[1], 16'h0100);
		host.wr(`OLCB_IDX_P6_FLOOR, 16'h0800, rsp);
		check("bad write answer", rsp, 2'b00);
		host.rd(`OLCB_IDX_BAD_ADDR, rdv, rsp);
		check("bad signed address", rdv, 32'h0051);
		$display("scaled test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire

// File: olcb_cfg.svh
// Offsets, field positions, reset values and limits of the output limit clamp bank
`ifndef OLCB_CFG_SVH
`define OLCB_CFG_SVH

// ----------------------------------------------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define OLCB_IDX_P5_FLOOR 6'h31
`define OLCB_IDX_P5_CEILING 6'h32
`define OLCB_IDX_P6_FLOOR 6'h33
`define OLCB_IDX_P6_CEILING 6'h34
`define OLCB_IDX_P7_FLOOR 6'h35
`define OLCB_IDX_P7_CEILING 6'h36
`define OLCB_IDX_P8_FLOOR 6'h37
`define OLCB_IDX_P8_CEILING 6'h38
`define OLCB_IDX_BAD_ADDR 6'h39
`define OLCB_IDX_CONFIG 6'h3a
`define OLCB_IDX_STATUS 6'h3b
`define OLCB_IDX_IRQ_CLEAR 6'h3c
`define OLCB_IDX_IRQ_ENABLE 6'h3d

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OLCB_FLOOR_RST 16'h0000
`define OLCB_CEILING_RST 16'h4095
`define OLCB_BAD_ADDR_RST 16'h0000
`define OLCB_CONFIG_RST 6'h10
`define OLCB_STATUS_RST 8'h00
`define OLCB_ENABLE_RST 8'h00

// ----------------------------------------------------------------------------
// Field positions of status, clear and enable words
// ----------------------------------------------------------------------------
`define OLCB_ST_LIMIT_OVER_LSB 0
`define OLCB_ST_CLAMPED_LSB 4

// ----------------------------------------------------------------------------
// Allowed ranges of the limit words
// ----------------------------------------------------------------------------
`define OLCB_UNSCALED_BCD_MAX 16'h4095
`define OLCB_UNSCALED_BIN_MAX 16'h0fff
`define OLCB_SIGNED_BIN_MIN 16'hf800
`define OLCB_SIGNED_BIN_MAX 16'h07ff
`define OLCB_SCALED_BIN_BAD 16'h8000
`define OLCB_BCD_NEG_DIGIT 4'hf
`define OLCB_BCD_TOP_MAX 4'h7
`define OLCB_BCD_DIGIT_MAX 4'h9

// ----------------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------------
`define OLCB_RESP_OKAY 2'b00
`define OLCB_RESP_SLVERR 2'b10

`endif

// File: olcb_host.sv
// Host controller model driving the register bus
`timescale 1ns/10ps
`default_nettype none
module olcb_host (
	input wire logic clock_i,
	input wire logic aw_rdy_i,
	input wire logic w_rdy_i,
	input wire logic [1:0] b_resp_i,
	input wire logic b_vld_i,
	input wire logic ar_rdy_i,
	input wire logic [31:0] r_data_i,
	input wire logic [1:0] r_resp_i,
	input wire logic r_vld_i,
	output logic [7:0] aw_addr_o,
	output logic aw_vld_o,
	output logic [31:0] w_data_o,
	output logic w_vld_o,
	output logic b_rdy_o,
	output logic [7:0] ar_addr_o,
	output logic ar_vld_o,
	output logic r_rdy_o
);
	// Slow mode holds off the answer ready until the answer shows
	logic slow = 1'b0;
	initial begin
		{aw_addr_o, aw_vld_o, w_data_o, w_vld_o, b_rdy_o, ar_addr_o, ar_vld_o, r_rdy_o} = '0;
	end
	task automatic wr(input logic [5:0] idx, input logic [15:0] d, output logic [1:0] r);
		@(posedge clock_i);
		aw_addr_o <= {idx, 2'b00};
		aw_vld_o <= 1'b1;
		w_data_o <= {16'h0000, d};
		w_vld_o <= 1'b1;
		b_rdy_o <= !slow;
		do begin
			@(posedge clock_i);
			if (aw_rdy_i) aw_vld_o <= 1'b0;
			if (w_rdy_i) w_vld_o <= 1'b0;
			// Raised once only, so the release after the loop is the sole write in that step
			if (b_vld_i && !b_rdy_o) b_rdy_o <= 1'b1;
		end while (!(b_vld_i && b_rdy_o));
		r = b_resp_i;
		b_rdy_o <= 1'b0;
	endtask
	// Word read, answer taken at the handshake edge
	task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock_i);
		ar_addr_o <= {idx, 2'b00};
		ar_vld_o <= 1'b1;
		r_rdy_o <= !slow;
		do begin
			@(posedge clock_i);
			if (ar_rdy_i) ar_vld_o <= 1'b0;
			if (r_vld_i && !r_rdy_o) r_rdy_o <= 1'b1;
		end while (!(r_vld_i && r_rdy_o));
		d = r_data_i;
		r = r_resp_i;
		r_rdy_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: olcb_pkg.sv
// Types shared by the output limit clamp bank
package olcb_pkg;

	// One point's pair of limit words
	typedef struct packed {
		logic [15:0] ceiling;
		logic [15:0] floor;
	} olcb_limit_t;

	// Software configuration of the bank
	typedef struct packed {
		logic signed_bin;
		logic bcd_fmt;
		logic [3:0] scale_en;
	} olcb_cfg_t;

endpackage
